/* core/rr2_pkg.sv */
// Constants and bus carriers for the second rectifier dead-time block.
// Assumes a 10 MHz core clock and an AXI4-Lite master on the register side.
package rr2_pkg;

  // ==========================================================================
  // Register map, index form; byte address is index times four
  localparam logic [9:0]  RISE_IDX  = 10'h055;
  localparam logic [9:0]  LEAD_IDX  = 10'h057;
  localparam logic [9:0]  CTRL_IDX  = 10'h058;
  localparam logic [9:0]  STAT_IDX  = 10'h059;
  localparam logic [11:0] RISE_ADDR = {RISE_IDX, 2'b00};
  localparam logic [11:0] LEAD_ADDR = {LEAD_IDX, 2'b00};
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_ADDR = {STAT_IDX, 2'b00};

  // ==========================================================================
  // Fields and reset values
  localparam int          CODE_W         = 8;
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          STAT_OUT_BIT   = 0;
  localparam int          STAT_VALID_BIT = 1;
  localparam int          STAT_LEN_LSB   = 16;
  localparam logic [7:0]  RISE_RST       = 8'h00;
  localparam logic [7:0]  LEAD_RST       = 8'h00;
  localparam logic        EN_RST         = 1'b0;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // Timing: code step and clock period in ns, cycles derived
  localparam logic [15:0] STEP_NS  = 16'h0005;
  localparam logic [15:0] CLK_NS   = 16'h0064;
  localparam logic [15:0] MAX_NS   = 16'h04fb;
  localparam int          MAX_CYC  = (MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int          CYC_W    = $clog2(MAX_CYC + 1);
  localparam int          CNT_W    = 16;

  // ==========================================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } rr2_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rr2_axi_rsp_t;

endpackage : rr2_pkg

/* core/rr2_code_cyc.sv */
// Converts a 5 ns dead-time code into whole core clock cycles, rounded up.
// Assumes the code is stable or changes only between switching cycles.
`timescale 1ns/1ns
module rr2_code_cyc import rr2_pkg::*; (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // Code in, cycles out
  input  wire logic [CODE_W-1:0] i_code,
  output logic      [CYC_W-1:0]  o_cycles
);

  logic [CYC_W-1:0] cycles_ff;
  logic [CYC_W-1:0] nxt_cycles;

  always_comb begin
    nxt_cycles = CYC_W'((16'(i_code) * STEP_NS + CLK_NS - 16'h0001) / CLK_NS);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cycles_ff <= '0;
    end else begin
      cycles_ff <= nxt_cycles;
    end
  end

  assign o_cycles = cycles_ff;

endmodule : rr2_code_cyc

/* core/rr2_phase.sv */
// Counts cycles since the last ac-sense falling edge and keeps the last
// measured low-phase length. Assumes edge pulses come from the core clock.
`timescale 1ns/1ns
module rr2_phase import rr2_pkg::*; (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Control and edges
  input  wire logic             i_run,
  input  wire logic             i_fall,
  input  wire logic             i_rise,
  // Measurements
  output logic      [CNT_W-1:0] o_count,
  output logic      [CNT_W-1:0] o_len,
  output logic                  o_len_valid,
  output logic                  o_in_low
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] len_ff;
  logic             valid_ff;
  logic             low_ff;

  // ==========================================================================
  // Elapsed counter, saturating
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= '0;
    end else if (!i_run) begin
      cnt_ff <= '0;
    end else if (i_fall) begin
      cnt_ff <= CNT_W'(1);
    end else if (cnt_ff != '1) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // ==========================================================================
  // Low-phase length capture
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      len_ff   <= '0;
      valid_ff <= 1'b0;
      low_ff   <= 1'b0;
    end else if (!i_run) begin
      valid_ff <= 1'b0;
      low_ff   <= 1'b0;
    end else if (i_fall) begin
      low_ff <= 1'b1;
    end else if (i_rise && low_ff) begin
      len_ff   <= cnt_ff;
      valid_ff <= 1'b1;
      low_ff   <= 1'b0;
    end
  end

  assign o_count     = cnt_ff;
  assign o_len       = len_ff;
  assign o_len_valid = valid_ff;
  assign o_in_low    = low_ff;

endmodule : rr2_phase

/* core/rr2_top.sv */
// Second rectifier drive timing in resonant mode, with AXI4-Lite registers.
// Assumes ac-sense is synchronous to the 10 MHz core clock.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rr2_top import rr2_pkg::*; (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Register bus
  input  wire rr2_axi_req_t i_axi,
  output rr2_axi_rsp_t      o_axi,
  // Power stage
  input  wire logic         i_ac_sense_input,
  output logic              o_second_rectifier_drive
);

  // ==========================================================================
  // Bus slave state
  logic              awready_ff;
  logic              wready_ff;
  logic              aw_have_ff;
  logic              w_have_ff;
  logic [11:0]       awaddr_ff;
  logic [31:0]       wdata_ff;
  logic              wstrb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;
  logic              wr_fire;
  logic              wr_hit;

  // Registers
  logic [CODE_W-1:0] rise_code_ff;
  logic [CODE_W-1:0] lead_code_ff;
  logic              en_ff;

  // Timing core
  logic              ac_prev_ff;
  logic              fall_ev;
  logic              rise_ev;
  logic [CYC_W-1:0]  rise_cyc;
  logic [CYC_W-1:0]  lead_cyc;
  logic [CYC_W-1:0]  act_rise_ff;
  logic [CYC_W-1:0]  act_lead_ff;
  logic [CYC_W-1:0]  cur_rise;
  logic [CYC_W-1:0]  cur_lead;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  len;
  logic              len_valid;
  logic              low_seen;
  logic [CNT_W-1:0]  elapsed;
  logic [CNT_W:0]    ahead;
  logic              in_low;
  logic              hit_on;
  logic              hit_off;
  logic              drive_ff;

  // ==========================================================================
  // Write channels: address and data in either order
  assign wr_fire = aw_have_ff && w_have_ff;
  assign wr_hit  = (awaddr_ff == RISE_ADDR) || (awaddr_ff == LEAD_ADDR) ||
                   (awaddr_ff == CTRL_ADDR) || (awaddr_ff == STAT_ADDR);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (awready_ff && i_axi.awvalid) begin
        aw_have_ff <= 1'b1;
        awaddr_ff  <= i_axi.awaddr;
        awready_ff <= 1'b0;
      end else if (!aw_have_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
      if (wready_ff && i_axi.wvalid) begin
        w_have_ff <= 1'b1;
        wdata_ff  <= i_axi.wdata;
        wstrb0_ff <= i_axi.wstrb[0];
        wready_ff <= 1'b0;
      end else if (!w_have_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && i_axi.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Register writes; status is read only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rise_code_ff <= RISE_RST;
      lead_code_ff <= LEAD_RST;
      en_ff        <= EN_RST;
    end else if (wr_fire && wstrb0_ff) begin
      if (awaddr_ff == RISE_ADDR) begin
        rise_code_ff <= wdata_ff[CODE_W-1:0];
      end
      if (awaddr_ff == LEAD_ADDR) begin
        lead_code_ff <= wdata_ff[CODE_W-1:0];
      end
      if (awaddr_ff == CTRL_ADDR) begin
        en_ff <= wdata_ff[CTRL_EN_BIT];
      end
    end
  end

  // ==========================================================================
  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (arready_ff && i_axi.arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
      unique case (i_axi.araddr)
        RISE_ADDR: rdata_ff[CODE_W-1:0] <= rise_code_ff;
        LEAD_ADDR: rdata_ff[CODE_W-1:0] <= lead_code_ff;
        CTRL_ADDR: rdata_ff[CTRL_EN_BIT] <= en_ff;
        STAT_ADDR: begin
          rdata_ff[STAT_OUT_BIT]                    <= drive_ff;
          rdata_ff[STAT_VALID_BIT]                  <= len_valid;
          rdata_ff[STAT_LEN_LSB +: CNT_W]           <= len;
        end
        default:   rresp_ff <= RESP_SLVERR;
      endcase
    end else if (rvalid_ff && i_axi.rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  always_comb begin
    o_axi.awready = awready_ff;
    o_axi.wready  = wready_ff;
    o_axi.bvalid  = bvalid_ff;
    o_axi.bresp   = bresp_ff;
    o_axi.arready = arready_ff;
    o_axi.rvalid  = rvalid_ff;
    o_axi.rdata   = rdata_ff;
    o_axi.rresp   = rresp_ff;
  end

  // ==========================================================================
  // Code conversion
  rr2_code_cyc u_rise_cyc (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_code   (rise_code_ff),
    .o_cycles (rise_cyc)
  );

  rr2_code_cyc u_lead_cyc (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_code   (lead_code_ff),
    .o_cycles (lead_cyc)
  );

  // ==========================================================================
  // Ac-sense edges and phase measurement
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ac_prev_ff <= 1'b0;
    end else begin
      ac_prev_ff <= i_ac_sense_input;
    end
  end

  assign fall_ev = en_ff && ac_prev_ff && !i_ac_sense_input;
  assign rise_ev = en_ff && !ac_prev_ff && i_ac_sense_input;

  rr2_phase u_phase (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_run       (en_ff),
    .i_fall      (fall_ev),
    .i_rise      (rise_ev),
    .o_count     (count),
    .o_len       (len),
    .o_len_valid (len_valid),
    .o_in_low    (low_seen)
  );

  // ==========================================================================
  // Active codes, taken only at the start of a switching cycle
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      act_rise_ff <= '0;
      act_lead_ff <= '0;
    end else if (fall_ev) begin
      act_rise_ff <= rise_cyc;
      act_lead_ff <= lead_cyc;
    end
  end

  // ==========================================================================
  // Drive edges: lead is placed against the last measured low phase
  assign cur_rise = fall_ev ? rise_cyc : act_rise_ff;
  assign cur_lead = fall_ev ? lead_cyc : act_lead_ff;
  assign elapsed  = fall_ev ? '0 : count;
  assign in_low   = fall_ev || low_seen;
  assign ahead    = {1'b0, elapsed} + (CNT_W + 1)'(cur_lead);
  assign hit_on   = in_low && (elapsed == CNT_W'(cur_rise)) &&
                    (!len_valid || (ahead < {1'b0, len}));
  assign hit_off  = !en_ff || rise_ev || (in_low && len_valid && (ahead >= {1'b0, len}));

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      drive_ff <= 1'b0;
    end else if (hit_off) begin
      drive_ff <= 1'b0;
    end else if (hit_on) begin
      drive_ff <= 1'b1;
    end
  end

  assign o_second_rectifier_drive = drive_ff;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  rise_delay_a: assert property ($rose(drive_ff) |->
    $past(elapsed) == CNT_W'($past(cur_rise)) && !$past(i_ac_sense_input))
    else $error("drive rose off its delay");

  fall_lead_a: assert property ($fell(drive_ff) && $past(en_ff) && !$past(rise_ev) |->
    $past(ahead) == {1'b0, $past(len)})
    else $error("drive fell off its lead");

  rise_code_a: assert property (1'b1 |=>
    (16'(rise_cyc) * CLK_NS >= 16'($past(rise_code_ff)) * STEP_NS) &&
    (rise_cyc == '0 || (16'(rise_cyc) - 16'h0001) * CLK_NS < 16'($past(rise_code_ff)) * STEP_NS))
    else $error("rise code cycles wrong");

  lead_code_a: assert property (1'b1 |=>
    (16'(lead_cyc) * CLK_NS >= 16'($past(lead_code_ff)) * STEP_NS) &&
    (lead_cyc == '0 || (16'(lead_cyc) - 16'h0001) * CLK_NS < 16'($past(lead_code_ff)) * STEP_NS))
    else $error("lead code cycles wrong");

  code_hold_a: assert property (!fall_ev |=> $stable(act_rise_ff) && $stable(act_lead_ff))
    else $error("active code changed mid cycle");

  // ==========================================================================
  // Mode, phase and code checks
  mode_off_a: assert property (!en_ff |=> !drive_ff)
    else $error("drive high out of resonant mode");

  high_quiet_a: assert property (!in_low |=> !$rose(drive_ff))
    else $error("drive rose in high phase");

  rise_gone_a: assert property (rise_ev |=> !drive_ff)
    else $error("drive high after sense rose");

  len_meas_a: assert property (rise_ev && low_seen |=> len_valid && len == $past(count))
    else $error("low phase length not captured");

  zero_rise_a: assert property (fall_ev && rise_cyc == '0 && (!len_valid || CNT_W'(lead_cyc) < len) |=>
    drive_ff)
    else $error("zero rise code delayed drive");

  rise_max_a: assert property (rise_code_ff == 8'hff |=> rise_cyc == CYC_W'(MAX_CYC))
    else $error("full rise code short of full delay");

  lead_max_a: assert property (lead_code_ff == 8'hff |=> lead_cyc == CYC_W'(MAX_CYC))
    else $error("full lead code short of full lead");

  rise_wr_a: assert property (wr_fire && wstrb0_ff && awaddr_ff == RISE_ADDR |=>
    rise_code_ff == $past(wdata_ff[CODE_W-1:0]))
    else $error("rise code write lost");

  lead_wr_a: assert property (wr_fire && wstrb0_ff && awaddr_ff == LEAD_ADDR |=>
    lead_code_ff == $past(wdata_ff[CODE_W-1:0]))
    else $error("lead code write lost");

  rise_seen_c: cover property ($rose(drive_ff));
  lead_fall_c: cover property ($fell(drive_ff) && !$past(rise_ev));
  write_done_c: cover property (bvalid_ff && i_axi.bready && bresp_ff == RESP_OKAY);
  code_mid_c: cover property (low_seen && wr_fire && awaddr_ff == RISE_ADDR);
  read_done_c: cover property (rvalid_ff && i_axi.rready);

endmodule : rr2_top

/* test/rr2_ac_src.sv */
// Behavioural ac-sense source standing in for the power stage; watches drive.
// Assumes phase lengths in core cycles and a registered drive from the block.
`timescale 1ns/1ns
module rr2_ac_src (
  // Clock and control
  input  wire logic        i_clk,
  input  wire logic        i_run,
  input  wire logic [15:0] i_low,
  input  wire logic [15:0] i_high,
  // Power stage pins
  input  wire logic        i_drive,
  output logic             o_sense,
  // Edge numbers of the last whole period, -1 when absent, and the count of periods begun
  output int               o_rise_at,
  output int               o_fall_at,
  output int               o_periods
);
  int   ph;
  int   edge_n;
  int   rise_q;
  int   fall_q;
  logic drive_q;

  initial begin
    o_sense   = 1'b1;
    o_rise_at = -1;
    o_fall_at = -1;
    o_periods = 0;
    ph        = 0;
    edge_n    = 0;
    rise_q    = -1;
    fall_q    = -1;
    drive_q   = 1'b0;
  end

  // ==========================================================================
  // Sense waveform: low for i_low cycles, then high for i_high cycles
  always @(posedge i_clk) begin
    if (!i_run) begin
      o_sense <= 1'b1;
      ph      <= i_low;
    end else if (ph + 1 >= i_low + i_high) begin
      o_sense   <= 1'b0;
      ph        <= 0;
      edge_n    <= 0;
      o_rise_at <= rise_q;
      o_fall_at <= fall_q;
      o_periods <= o_periods + 1;
    end else begin
      o_sense <= (ph + 1 >= i_low);
      ph      <= ph + 1;
      edge_n  <= edge_n + 1;
    end
  end

  // ==========================================================================
  // Drive edges, sampled once the clock edge has settled
  always @(negedge i_clk) begin
    // Edge number zero opens a new period: forget the old edges
    if (i_drive === 1'b1 && !drive_q) rise_q <= edge_n;
    else if (edge_n == 0) rise_q <= -1;
    if (i_drive === 1'b0 && drive_q) fall_q <= edge_n;
    else if (edge_n == 0) fall_q <= -1;
    drive_q <= (i_drive === 1'b1);
  end
endmodule : rr2_ac_src

/* test/rr2_top_tb.sv */
// Self-checking bench for the second rectifier drive timing block.
// Assumes an AXI4-Lite master here and the ac-sense model at the far side.
`timescale 1ns/1ns
module rr2_top_tb import rr2_pkg::*; ;
  logic         i_clk   = 1'b0;
  logic         i_reset = 1'b1;
  rr2_axi_req_t req     = '0;
  rr2_axi_rsp_t rsp;
  logic         sense;
  logic         drive;
  logic         run     = 1'b0;
  logic [15:0]  low_n   = 16'h000c;
  logic [15:0]  high_n  = 16'h0006;
  int           rise_at;
  int           fall_at;
  int           periods;
  int           fails   = 0;
  int           checked = 0;

  always #50 i_clk = ~i_clk;

  rr2_top u_rr2_top (
    .i_clk(i_clk), .i_reset(i_reset), .i_axi(req), .o_axi(rsp),
    .i_ac_sense_input(sense), .o_second_rectifier_drive(drive)
  );

  rr2_ac_src u_rr2_ac_src (
    .i_clk(i_clk), .i_run(run), .i_low(low_n), .i_high(high_n), .i_drive(drive),
    .o_sense(sense), .o_rise_at(rise_at), .o_fall_at(fall_at), .o_periods(periods)
  );

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_periods(input int n);
    int target;
    target = periods + n;
    while (periods < target) @(posedge i_clk);
  endtask : wait_periods

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  task automatic test_regs;
    logic [31:0] v;
    logic [1:0]  r;
    axi_rd(RISE_ADDR, v, r);
    check("rise reset", v, {24'h0, RISE_RST});
    axi_rd(LEAD_ADDR, v, r);
    check("lead reset", v, {24'h0, LEAD_RST});
    axi_wr(RISE_ADDR, 32'h1234_56ab, r);
    check("rise wr resp", {30'h0, r}, {30'h0, RESP_OKAY});
    axi_rd(RISE_ADDR, v, r);
    check("rise code", v, 32'h0000_00ab);
    axi_wr(LEAD_ADDR, 32'hffff_ff5a, r);
    axi_rd(LEAD_ADDR, v, r);
    check("lead code", v, 32'h0000_005a);
    axi_wr(12'h100, 32'h0000_0001, r);
    check("unmapped wr", {30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(12'h100, v, r);
    check("unmapped rd", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped data", v, 32'h0);
    $display("test_regs done");
  endtask : test_regs

  task automatic test_timing;
    logic [7:0]  rc [8] = '{8'h00, 8'h01, 8'h14, 8'h28, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0]  lc [8] = '{8'h00, 8'h01, 8'h28, 8'h14, 8'hff, 8'hff, 8'h00, 8'h00};
    logic [15:0] nn [8] = '{16'h000c, 16'h000c, 16'h000c, 16'h000c, 16'h001e, 16'h0014, 16'h000e, 16'h001e};
    int          d;
    int          l;
    logic [31:0] v;
    logic [1:0]  r;
    run <= 1'b1;
    axi_wr(CTRL_ADDR, 32'h1, r);
    for (int i = 0; i < 8; i++) begin
      low_n <= nn[i];
      axi_wr(RISE_ADDR, {24'h0, rc[i]}, r);
      axi_wr(LEAD_ADDR, {24'h0, lc[i]}, r);
      wait_periods(3);
      d = (rc[i] * STEP_NS + CLK_NS - 1) / CLK_NS;
      l = (lc[i] * STEP_NS + CLK_NS - 1) / CLK_NS;
      check("rise edge", rise_at, (d + l >= nn[i]) ? -1 : d + 1);
      check("fall edge", fall_at, (d + l >= nn[i]) ? -1 : nn[i] - l + 1);
      axi_rd(STAT_ADDR, v, r);
      check("low length", {16'h0, v[31:16]}, {16'h0, nn[i]});
      check("low valid", {31'h0, v[STAT_VALID_BIT]}, 32'h1);
    end
    // Code change inside a low phase keeps the pending edge
    wait_periods(1);
    axi_wr(RISE_ADDR, 32'h0, r);
    wait_periods(1);
    check("rise kept", rise_at, 14);
    wait_periods(1);
    check("rise new", rise_at, 1);
    $display("test_timing done");
  endtask : test_timing

  task automatic test_disable;
    logic [31:0] v;
    logic [1:0]  r;
    axi_wr(CTRL_ADDR, 32'h0, r);
    wait_periods(3);
    check("rise off", rise_at, -1);
    check("drive off", {31'h0, drive}, 32'h0);
    axi_rd(CTRL_ADDR, v, r);
    check("enable off", v, 32'h0);
    axi_rd(STAT_ADDR, v, r);
    check("status off", {30'h0, v[STAT_VALID_BIT], v[STAT_OUT_BIT]}, 32'h0);
    $display("test_disable done");
  endtask : test_disable

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    test_regs;
    test_timing;
    test_disable;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    $display("watchdog expired");
    final_report;
  end
endmodule : rr2_top_tb
